// file: hw/frms_pkg.sv
// frms_pkg: constants and types shared by the flash read-mode and status logic
package frms_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int FRMS_AW = 12;
  localparam int FRMS_DW = 16;
  localparam int FRMS_NSECT = 8;
  localparam int FRMS_NSECT_SEC = 4;
  localparam int FRMS_LANES = 2;
  localparam int FRMS_UPPER_OFS = 8;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  localparam logic [11:0] FRMS_CODE1_ADDR = 12'hAAA;
  localparam logic [11:0] FRMS_CODE2_ADDR = 12'h554;
  localparam logic [7:0] FRMS_CODE1_BYTE = 8'hAA;
  localparam logic [7:0] FRMS_CODE2_BYTE = 8'h55;
  localparam logic [7:0] FRMS_CMD_QUERY = 8'h90;
  localparam logic [7:0] FRMS_CMD_PROG = 8'hA0;
  localparam logic [7:0] FRMS_CMD_ERASE = 8'h80;
  localparam logic [7:0] FRMS_CMD_SECT = 8'h30;
  localparam logic [7:0] FRMS_CMD_BULK = 8'h10;
  localparam logic [7:0] FRMS_CMD_RESET = 8'hF0;
  localparam logic [7:0] FRMS_ALL_MAIN = 8'hFF;
  localparam logic [7:0] FRMS_ALL_SEC = 8'h0F;

  // ----------------------------------------------------------------
  // query reads
  // ----------------------------------------------------------------
  localparam logic [7:0] FRMS_ID_ADDR = 8'h02;
  localparam logic [1:0] FRMS_PROT_A10 = 2'b10;
  localparam logic [7:0] FRMS_ID_CODE = 8'h5A; // arbitrary value
  localparam logic [7:0] FRMS_PROT_YES = 8'h01;
  localparam logic [7:0] FRMS_PROT_NO = 8'h00;

  // ----------------------------------------------------------------
  // status bit positions in the low lane
  // ----------------------------------------------------------------
  localparam int FRMS_POLL_POS = 7;
  localparam int FRMS_TOGGLE_POS = 6;
  localparam int FRMS_ERROR_POS = 5;
  localparam int FRMS_WINDOW_POS = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FRMS_CLK_MHZ = 25;
  localparam int FRMS_WIN_US = 100;
  localparam int FRMS_NOERASE_US = 100;
  localparam logic [11:0] FRMS_WIN_CYC = 12'(FRMS_WIN_US * FRMS_CLK_MHZ);
  localparam logic [11:0] FRMS_NOERASE_CYC = 12'(FRMS_NOERASE_US * FRMS_CLK_MHZ);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_READ  = 4'h0,
    ST_C1    = 4'h1,
    ST_C2    = 4'h2,
    ST_PROG  = 4'h3,
    ST_E3    = 4'h4,
    ST_E4    = 4'h5,
    ST_E5    = 4'h6,
    ST_WIN   = 4'h7,
    ST_QUERY = 4'h8,
    ST_BUSY  = 4'h9
  } frms_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
    logic [7:0] main_sel;
    logic [3:0] sec_sel;
    logic rd_n;
    logic wr_n;
  } frms_bus_s;

  typedef struct packed {
    logic poll;
    logic toggle;
    logic error;
    logic window;
  } frms_stat_s;

  typedef struct packed {
    frms_bus_s s1;
    frms_bus_s s2;
    logic rd_q;
    logic wr_q;
    frms_state_e st;
    logic flash;
    logic [7:0] sectors;
    logic [11:0] addr;
    logic [15:0] data;
    logic [11:0] cnt;
    logic erase;
    logic fake;
    logic toggle;
    logic err;
    logic [15:0] rdata;
    logic rvalid;
    logic prog_req;
    logic erase_req;
    logic array_mode;
  } frms_core_s;

  // pins idle: strobes high, no select
  localparam frms_bus_s FRMS_BUS_IDLE = '{addr: 12'h000, data: 16'h0000, main_sel: 8'h00,
                                         sec_sel: 4'h0, rd_n: 1'b1, wr_n: 1'b1};

endpackage : frms_pkg

// file: hw/frms_status_byte.sv
// frms_status_byte: places the status flags on both byte lanes of a read word
`timescale 1ns/1ps
module frms_status_byte
  import frms_pkg::*;
(
  // flags
  input frms_stat_s i_stat,
  // word
  output logic [15:0] o_word
);

  // ----------------------------------------------------------------
  // lane placement
  // ----------------------------------------------------------------
  // undefined positions are driven zero; software must not rely on it
  always_comb begin
    o_word = 16'h0000;
    for (int lane = 0; lane < FRMS_LANES; lane++) begin
      o_word[FRMS_POLL_POS + lane * FRMS_UPPER_OFS] = i_stat.poll;
      o_word[FRMS_TOGGLE_POS + lane * FRMS_UPPER_OFS] = i_stat.toggle;
      o_word[FRMS_ERROR_POS + lane * FRMS_UPPER_OFS] = i_stat.error;
      o_word[FRMS_WINDOW_POS + lane * FRMS_UPPER_OFS] = i_stat.window;
    end
  end

endmodule : frms_status_byte

// file: hw/frms_read_mode.sv
// frms_read_mode: read-array, query and status-flag logic of the dual flash
`timescale 1ns/1ps
// Summary of operation
// - After power-up both flashes start in read-array mode, reading like a ROM.
// - Read-array mode after power-up, reset or reset instruction; plain reads otherwise.
// - Identifier query answers only on the main flash, never the secondary.
// - Protection query read returns 01h if protected, 00h if not.
// - During an algorithm, even reads return poll, toggle, error, erase-window bits.
// - Status bits 4, 2, 1, 0 have no guaranteed value.
// - Status bits are mirrored on the upper byte lane at 15, 14, 13, 11.
// - Programming: poll bit is inverted data bit 7, true data afterwards.
// - Status valid after fourth program or sixth erase write; poll the target.
// - Erase: poll bit reads zero, then stored data once complete.
// - Program into a protected sector is ignored.
// - All-protected erase: no erase, status shown for about 100 us.
// - Toggle bit inverts on each even-word read of the busy flash.
// - When done, toggling stops and reads return memory contents.
// - Error bit zero normally, one on program or erase failure.
// - Error bit stays set until a reset instruction clears it.
// - Erase-window bit zero for 100 us after each sector erase, restarted.
// - Sequences open with AAh at AAAh then 55h at 554h, upper data byte ignored.
// - Protection read needs the sector select with A1 high, A0 low.
// - Query mode lasts until a reset instruction returns read-array mode.
module frms_read_mode
  import frms_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // host bus pins
  input wire logic [11:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_main_flash_sector_select,
  input wire logic [3:0] i_secondary_flash_sector_select,
  // arrays and protection
  input wire logic [15:0] i_main_array_data,
  input wire logic [15:0] i_secondary_array_data,
  input wire logic [7:0] i_main_protect,
  input wire logic [3:0] i_secondary_protect,
  // embedded algorithm engine
  input wire logic i_engine_done,
  input wire logic i_engine_fail,
  // read answer
  output logic [15:0] o_rdata,
  output logic o_rdata_valid,
  // algorithm requests
  output logic o_prog_req,
  output logic o_erase_req,
  output logic o_op_flash,
  output logic [11:0] o_op_addr,
  output logic [15:0] o_op_data,
  output logic [7:0] o_op_sectors,
  // mode
  output logic o_error_flag,
  output logic o_read_array_mode
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sel_of(input frms_bus_s b, input logic flash);
    sel_of = flash ? {4'h0, b.sec_sel} : b.main_sel;
  endfunction : sel_of

  function automatic logic [7:0] prot_of(input logic flash, input logic [7:0] mp,
                                         input logic [3:0] sp);
    prot_of = flash ? {4'h0, sp} : mp;
  endfunction : prot_of

  frms_core_s core;
  frms_core_s next_core;
  frms_stat_s stat;
  frms_bus_s pins;
  logic [15:0] status_word;
  logic [7:0] flash_sel;
  logic [7:0] flash_prot;
  logic any_sel;
  logic tgt;
  logic same;
  logic hit;
  logic rd_fall;
  logic wr_rise;
  logic status_rd;
  logic query_rd;
  logic id_rd;
  logic prot_rd;
  logic prot_hit;
  logic f0_wr;
  logic running;
  logic [7:0] cmd;

  // ----------------------------------------------------------------
  // combinational view of the synchronised bus
  // ----------------------------------------------------------------
  assign pins = '{addr: i_addr, data: i_wdata, main_sel: i_main_flash_sector_select,
                  sec_sel: i_secondary_flash_sector_select, rd_n: i_rd_n, wr_n: i_wr_n};
  assign cmd = core.s2.data[7:0];
  assign any_sel = (|core.s2.main_sel) | (|core.s2.sec_sel);
  assign tgt = ~(|core.s2.main_sel); // main wins if both are selected
  assign same = (tgt == core.flash);
  assign flash_sel = sel_of(core.s2, core.flash);
  assign flash_prot = prot_of(core.flash, i_main_protect, i_secondary_protect);
  assign hit = |flash_sel;
  assign prot_hit = |(flash_sel & flash_prot);
  // edges are taken from the second stage, never from the first
  assign rd_fall = core.rd_q & ~core.s2.rd_n;
  assign wr_rise = ~core.wr_q & core.s2.wr_n;
  assign running = (core.st == ST_BUSY) || (core.st == ST_WIN);
  // status only on even words of the flash running the algorithm
  assign status_rd = rd_fall && hit && !core.s2.addr[0] && (running || core.err);
  assign query_rd = rd_fall && hit && (core.st == ST_QUERY);
  assign id_rd = query_rd && !core.flash && (core.s2.addr[7:0] == FRMS_ID_ADDR);
  assign prot_rd = query_rd && !id_rd && (core.s2.addr[1:0] == FRMS_PROT_A10);
  assign f0_wr = wr_rise && any_sel && (cmd == FRMS_CMD_RESET) &&
                 (core.st != ST_BUSY) && (core.st != ST_PROG);

  // status flags: erase polls zero, program polls inverted bit 7
  assign stat = '{poll: core.erase ? 1'b0 : ~core.data[7],
                  toggle: core.toggle,
                  error: core.err,
                  window: (core.st != ST_WIN)};

  frms_status_byte u_status (
    .i_stat (stat),
    .o_word (status_word)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic launch;
    logic [7:0] live;
    launch = 1'b0;
    live = 8'h00;
    next_core = core;
    next_core.s1 = pins;
    next_core.s2 = core.s1;
    next_core.rd_q = core.s2.rd_n;
    next_core.wr_q = core.s2.wr_n;
    next_core.rvalid = 1'b0;
    next_core.prog_req = 1'b0;
    next_core.erase_req = 1'b0;

    // read path: array by default, status or query data when due
    if (rd_fall && any_sel) begin
      next_core.rvalid = 1'b1;
      next_core.rdata = tgt ? i_secondary_array_data : i_main_array_data;
      if (status_rd) begin
        next_core.rdata = status_word;
        if (running) begin
          next_core.toggle = ~core.toggle;
        end
      end else if (id_rd) begin
        next_core.rdata = {8'h00, FRMS_ID_CODE};
      end else if (prot_rd) begin
        next_core.rdata = {8'h00, prot_hit ? FRMS_PROT_YES : FRMS_PROT_NO};
      end
    end

    // erase window: expiry launches the erase
    if (core.st == ST_WIN) begin
      next_core.cnt = core.cnt - 12'h001;
      launch = (core.cnt == 12'h001);
    end

    // instruction decoder; writes are ignored in ST_BUSY, still accepted in the erase window
    if (wr_rise && any_sel && core.st != ST_BUSY) begin
      if (f0_wr) begin
        next_core.st = ST_READ;
        next_core.err = 1'b0;
        launch = 1'b0;
      end else if (!core.err) begin
        unique case (core.st)
          ST_READ: begin
            if (cmd == FRMS_CODE1_BYTE && core.s2.addr == FRMS_CODE1_ADDR) begin
              next_core.st = ST_C1;
              next_core.flash = tgt;
            end
          end
          ST_C1, ST_E4: begin
            if (same && cmd == FRMS_CODE2_BYTE && core.s2.addr == FRMS_CODE2_ADDR) begin
              next_core.st = (core.st == ST_C1) ? ST_C2 : ST_E5;
            end else begin
              next_core.st = ST_READ;
            end
          end
          ST_C2: begin
            next_core.st = ST_READ;
            if (same && core.s2.addr == FRMS_CODE1_ADDR) begin
              if (cmd == FRMS_CMD_QUERY) next_core.st = ST_QUERY;
              if (cmd == FRMS_CMD_PROG) next_core.st = ST_PROG;
              if (cmd == FRMS_CMD_ERASE) next_core.st = ST_E3;
            end
          end
          ST_PROG: begin
            next_core.addr = core.s2.addr;
            next_core.data = core.s2.data;
            next_core.erase = 1'b0;
            if (!same || prot_hit) begin
              next_core.st = ST_READ;
            end else begin
              next_core.prog_req = 1'b1;
              next_core.st = ST_BUSY;
            end
          end
          ST_E3: begin
            next_core.st = (same && cmd == FRMS_CODE1_BYTE && core.s2.addr == FRMS_CODE1_ADDR)
                           ? ST_E4 : ST_READ;
          end
          ST_E5, ST_WIN: begin
            if (same && cmd == FRMS_CMD_SECT) begin
              next_core.sectors = (core.st == ST_WIN) ? (core.sectors | flash_sel) : flash_sel;
              next_core.cnt = FRMS_WIN_CYC;
              next_core.st = ST_WIN;
              // polls read as erase from the sixth write on, not only after launch
              next_core.erase = 1'b1;
              launch = 1'b0;
            end else if (core.st == ST_E5 && same && cmd == FRMS_CMD_BULK &&
                         core.s2.addr == FRMS_CODE1_ADDR) begin
              next_core.sectors = core.flash ? FRMS_ALL_SEC : FRMS_ALL_MAIN;
              launch = 1'b1;
            end else begin
              next_core.st = ST_READ; // any other write aborts the erase
              launch = 1'b0;
            end
          end
          ST_QUERY, ST_BUSY: begin
          end
        endcase
      end
    end

    // start the erase on unprotected sectors, or fake it if none are left
    if (launch) begin
      live = next_core.sectors & ~flash_prot;
      next_core.erase = 1'b1;
      next_core.st = ST_BUSY;
      next_core.sectors = live;
      next_core.fake = (live == 8'h00);
      next_core.erase_req = (live != 8'h00);
      next_core.cnt = FRMS_NOERASE_CYC;
    end

    // algorithm end; a failure sets the error flag, which beats any clear
    if (core.st == ST_BUSY) begin
      if (core.fake) begin
        next_core.cnt = core.cnt - 12'h001;
        if (core.cnt == 12'h001) begin
          next_core.st = ST_READ;
          next_core.fake = 1'b0;
        end
      end else if (i_engine_done || i_engine_fail) begin
        next_core.st = ST_READ;
      end
      if (!core.fake && i_engine_fail) begin
        next_core.err = 1'b1;
      end
    end

    next_core.array_mode = (next_core.st == ST_READ) && !next_core.err;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // pin stages reset to idle so no strobe edge is seen at release
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      core <= '0;
      core.s1 <= FRMS_BUS_IDLE;
      core.s2 <= FRMS_BUS_IDLE;
      core.rd_q <= 1'b1;
      core.wr_q <= 1'b1;
      core.array_mode <= 1'b1;
    end else begin
      core <= next_core;
    end
  end

  // outputs straight from the state register
  assign o_rdata = core.rdata;
  assign o_rdata_valid = core.rvalid;
  assign o_prog_req = core.prog_req;
  assign o_erase_req = core.erase_req;
  assign o_op_flash = core.flash;
  assign o_op_addr = core.addr;
  assign o_op_data = core.data;
  assign o_op_sectors = core.sectors;
  assign o_error_flag = core.err;
  assign o_read_array_mode = core.array_mode;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_reset_cmd;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    f0_wr |=> (core.st == ST_READ) && !o_error_flag && o_read_array_mode;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset instruction ignored");

  property p_no_sec_id;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (query_rd && core.flash && core.s2.addr[7:0] == FRMS_ID_ADDR) |=>
      o_rdata_valid && (o_rdata[7:0] != FRMS_ID_CODE);
  endproperty
  a_no_sec_id: assert property (p_no_sec_id) else $error("secondary gave identifier");

  property p_prot_read;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    prot_rd |=> o_rdata == {8'h00, $past(prot_hit) ? FRMS_PROT_YES : FRMS_PROT_NO};
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("bad protection status");

  property p_lanes;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    status_rd |=> (o_rdata[15:11] == o_rdata[7:3]) && (o_rdata[5] == $past(stat.error));
  endproperty
  a_lanes: assert property (p_lanes) else $error("status lanes differ");

  property p_prog_poll;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (status_rd && core.st == ST_BUSY && !core.erase) |=> o_rdata[7] == !$past(core.data[7]);
  endproperty
  a_prog_poll: assert property (p_prog_poll) else $error("program poll bit wrong");

  property p_erase_poll;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (status_rd && core.erase) |=> !o_rdata[7] && !o_rdata[15];
  endproperty
  a_erase_poll: assert property (p_erase_poll) else $error("erase poll bit not zero");

  property p_prot_prog;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (wr_rise && any_sel && core.st == ST_PROG && !core.err && same && prot_hit) |=>
      !o_prog_req && core.st == ST_READ;
  endproperty
  a_prot_prog: assert property (p_prot_prog) else $error("protected program started");

  property p_noerase;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    ((core.st == ST_WIN && core.cnt == 12'h001 && !wr_rise &&
      (core.sectors & ~flash_prot) == 8'h00) ||
     (wr_rise && any_sel && !core.err && same && core.st == ST_E5 && cmd == FRMS_CMD_BULK &&
      core.s2.addr == FRMS_CODE1_ADDR &&
      ((core.flash ? FRMS_ALL_SEC : FRMS_ALL_MAIN) & ~flash_prot) == 8'h00))
      |=> !o_erase_req && core.fake && core.cnt == FRMS_NOERASE_CYC;
  endproperty
  a_noerase: assert property (p_noerase) else $error("all-protected erase started");

  property p_toggle;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (status_rd && running) |=>
      (o_rdata[6] == $past(core.toggle)) && (core.toggle != $past(core.toggle));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not invert");

  property p_err_set;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (core.st == ST_BUSY && !core.fake && i_engine_fail) |=> o_error_flag ##1 o_error_flag;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_err_hold;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (o_error_flag && !f0_wr) |=> o_error_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");

  property p_win_start;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (wr_rise && any_sel && !core.err && same && cmd == FRMS_CMD_SECT &&
     (core.st == ST_E5 || core.st == ST_WIN)) |=> core.st == ST_WIN && core.cnt == FRMS_WIN_CYC;
  endproperty
  a_win_start: assert property (p_win_start) else $error("erase window not restarted");

endmodule : frms_read_mode

// file: dv/frms_host_model.sv
// frms_host_model: microcontroller bus master driving the flash pins
`timescale 1ns/1ps
module frms_host_model
  import frms_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // read answer
  input wire logic [15:0] i_rdata,
  input wire logic i_rdata_valid,
  // bus pins
  output frms_bus_s o_bus
);
  // selects and strobes idle from time zero
  initial o_bus = FRMS_BUS_IDLE;
  // write: strobe low 3 clocks, pins held 3 clocks after it rises
  task automatic wr(input logic [11:0] s, input logic [11:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    {o_bus.sec_sel, o_bus.main_sel} = s;
    o_bus.addr = a;
    o_bus.data = d;
    o_bus.wr_n = 1'b0;
    repeat (3) @(negedge i_core_clk);
    o_bus.wr_n = 1'b1;
    repeat (3) @(negedge i_core_clk);
    {o_bus.sec_sel, o_bus.main_sel} = 12'h000;
    o_bus.data = ~d; // released lines must not keep the old word
  endtask : wr
  // read: strobe held until the answer shows or 12 clocks pass, then high 3 clocks
  task automatic rd(input logic [11:0] s, input logic [11:0] a, output logic [15:0] q);
    q = 16'hXXXX;
    @(negedge i_core_clk);
    {o_bus.sec_sel, o_bus.main_sel} = s;
    o_bus.addr = a;
    o_bus.rd_n = 1'b0;
    for (int n = 0; n < 12; n++) begin
      @(negedge i_core_clk);
      if (i_rdata_valid === 1'b1) begin
        q = i_rdata;
        break;
      end
    end
    o_bus.rd_n = 1'b1;
    repeat (3) @(negedge i_core_clk);
    {o_bus.sec_sel, o_bus.main_sel} = 12'h000;
    o_bus.addr = ~a;
  endtask : rd
endmodule : frms_host_model

// file: dv/flash_read_mode_status_flags_tb.sv
// flash_read_mode_status_flags_tb: random and corner tests of the read and status logic
`timescale 1ns/1ps
module flash_read_mode_status_flags_tb
  import frms_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [15:0] mdat = 16'h1234;
  logic [15:0] sdat = 16'h5678;
  logic [7:0] mprot = 8'h00;
  logic [3:0] sprot = 4'h0;
  logic done = 1'b0;
  logic fail = 1'b0;
  frms_bus_s bus;
  logic [15:0] rdata, odata;
  logic [11:0] oaddr;
  logic [7:0] osect;
  logic rvalid, preq, ereq, err, ram, oflash;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_prog = 0;
  int n_erase = 0;
  int cyc = 0;
  frms_read_mode DUT (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(bus.addr),
    .i_wdata(bus.data), .i_rd_n(bus.rd_n), .i_wr_n(bus.wr_n),
    .i_main_flash_sector_select(bus.main_sel), .i_secondary_flash_sector_select(bus.sec_sel),
    .i_main_array_data(mdat), .i_secondary_array_data(sdat), .i_main_protect(mprot),
    .i_secondary_protect(sprot), .i_engine_done(done), .i_engine_fail(fail),
    .o_rdata(rdata), .o_rdata_valid(rvalid), .o_prog_req(preq), .o_erase_req(ereq),
    .o_op_flash(oflash), .o_op_addr(oaddr), .o_op_data(odata), .o_op_sectors(osect),
    .o_error_flag(err), .o_read_array_mode(ram));
  frms_host_model host (.i_core_clk(i_core_clk), .i_rdata(rdata), .i_rdata_valid(rvalid),
    .o_bus(bus));
  initial forever #20 i_core_clk = ~i_core_clk;
  // pulses counted here so no task must catch a one-cycle request
  always @(posedge i_core_clk) begin
    if (preq === 1'b1) n_prog++;
    if (ereq === 1'b1) n_erase++;
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    chk_word({15'h0000, g}, {15'h0000, e});
  endtask : chk_bit
  function automatic logic [15:0] stat(input logic p, input logic e, input logic w);
    return {2{p, 1'b0, e, 1'b0, w, 3'b000}};
  endfunction : stat
  // two status reads: fixed bits match, toggle flips only while busy
  task automatic status2(input logic [11:0] s, input logic [11:0] a, input logic [15:0] e,
      input logic t);
    logic [15:0] q, q2;
    host.rd(s, a, q);
    host.rd(s, a, q2);
    chk_word(q & 16'hBFBF, e);
    chk_bit(q[14], q[6]);
    chk_bit(q2[6], q[6] ^ t);
  endtask : status2
  task automatic cmd(input logic [11:0] s, input logic [7:0] c);
    host.wr(s, FRMS_CODE1_ADDR, {8'h00, FRMS_CODE1_BYTE});
    host.wr(s, FRMS_CODE2_ADDR, {8'h00, FRMS_CODE2_BYTE});
    host.wr(s, FRMS_CODE1_ADDR, {8'h00, c});
  endtask : cmd
  task automatic pulse(input logic f);
    @(negedge i_core_clk);
    done = !f;
    fail = f;
    @(negedge i_core_clk);
    done = 1'b0;
    fail = 1'b0;
  endtask : pulse
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    logic [15:0] d, q;
    logic [11:0] s, a;
    int k, n;
    d = 16'($urandom(81833));
    repeat (16) @(negedge i_core_clk);
    i_reset_n = 1'b1;
    @(negedge i_core_clk);
    chk_bit(ram, 1'b1);
    for (int i = 0; i < 4; i++) begin
      mdat = 16'($urandom);
      sdat = 16'($urandom);
      a = 12'($urandom);
      host.rd(12'(1 << i), a, q);
      chk_word(q, mdat);
      host.rd(12'(1 << (8 + i)), a, q);
      chk_word(q, sdat);
    end
    $display("test read done");
    mprot = 8'($urandom);
    sprot = 4'($urandom);
    k = $urandom_range(3, 0);
    cmd(12'(1 << k), FRMS_CMD_QUERY);
    host.rd(12'(1 << k), 12'h002, q);
    chk_word(q, {8'h00, FRMS_ID_CODE});
    host.rd(12'(1 << k), 12'hFF6, q);
    chk_word(q, {15'h0000, mprot[k]});
    host.wr(12'(1 << k), 12'h000, {8'h00, FRMS_CMD_RESET});
    host.rd(12'(1 << k), 12'h002, q);
    chk_word(q, mdat);
    cmd(12'(1 << (8 + k)), FRMS_CMD_QUERY);
    host.rd(12'(1 << (8 + k)), 12'h002, q);
    chk_word(q, {15'h0000, sprot[k]});
    host.wr(12'(1 << (8 + k)), 12'h000, {8'h00, FRMS_CMD_RESET});
    $display("test query done");
    // program: plain, into a protected sector, then one that fails
    for (int i = 0; i < 3; i++) begin
      k = $urandom_range(7, 0);
      s = 12'(1 << k);
      mprot[k] = (i == 1);
      a = 12'($urandom) & 12'hFFE;
      d = 16'($urandom);
      n = n_prog;
      cmd(s, FRMS_CMD_PROG);
      host.wr(s, a, d);
      repeat (2) @(negedge i_core_clk);
      chk_word(16'(n_prog - n), 16'(i != 1));
      if (i != 1) begin
        chk_word(odata, d);
        chk_word({4'h0, oaddr}, {4'h0, a});
        chk_bit(oflash, 1'b0);
        status2(s, a, stat(~d[7], 1'b0, 1'b1), 1'b1);
        host.rd(12'h100, a, q);
        chk_word(q, sdat);
        pulse(i == 2);
      end
      if (i == 2) begin
        status2(s, a, stat(~d[7], 1'b1, 1'b1), 1'b0);
        chk_bit(err, 1'b1);
        chk_bit(ram, 1'b0);
        host.wr(s, 12'h000, {8'h00, FRMS_CMD_RESET});
      end
      host.rd(s, a, q);
      chk_word(q, mdat);
      chk_bit(err, 1'b0);
    end
    $display("test program done");
    // two-sector erase: the second sector restarts the window
    k = $urandom_range(6, 0);
    mprot = 8'($urandom) & ~(8'h03 << k);
    s = 12'(1 << k);
    n = n_erase;
    cmd(s, FRMS_CMD_ERASE);
    cmd(s, FRMS_CMD_SECT);
    status2(s, 12'h000, stat(1'b0, 1'b0, 1'b0), 1'b1);
    repeat (1500) @(negedge i_core_clk);
    host.wr(12'(2 << k), 12'h000, {8'h00, FRMS_CMD_SECT});
    repeat (1500) @(negedge i_core_clk);
    chk_word(16'(n_erase - n), 16'h0000);
    repeat (1100) @(negedge i_core_clk);
    chk_word(16'(n_erase - n), 16'h0001);
    chk_word({8'h00, osect}, {8'h00, 8'h03 << k});
    status2(s, 12'h000, stat(1'b0, 1'b0, 1'b1), 1'b1);
    pulse(1'b0);
    host.wr(s, 12'h000, {8'h00, FRMS_CMD_RESET});
    host.rd(s, 12'h000, q);
    chk_word(q, mdat);
    // bulk erase of a fully protected secondary flash shows status only
    sprot = 4'hF;
    s = 12'h100 << $urandom_range(3, 0);
    n = n_erase;
    cmd(s, FRMS_CMD_ERASE);
    cmd(s, FRMS_CMD_BULK);
    chk_bit(oflash, 1'b1);
    status2(s, 12'h004, stat(1'b0, 1'b0, 1'b1), 1'b1);
    host.rd(12'h001, 12'h004, q);
    chk_word(q, mdat);
    repeat (2000) @(negedge i_core_clk);
    status2(s, 12'h004, stat(1'b0, 1'b0, 1'b1), 1'b1);
    repeat (600) @(negedge i_core_clk);
    host.rd(s, 12'h004, q);
    chk_word(q, sdat);
    chk_word(16'(n_erase - n), 16'h0000);
    $display("test erase done");
    report_and_stop();
  end
endmodule : flash_read_mode_status_flags_tb
